// >>> hdl/card_reader_defs.svh
// Constants for the card reader host port: field positions and codes
`ifndef CARD_READER_DEFS_SVH
`define CARD_READER_DEFS_SVH
// Command field (address bits 1:0)
`define CMD_READ_DATA 2'h0
`define CMD_LEVEL_ONE 2'h1
`define CMD_ILLEGAL 2'h2
`define CMD_LEVEL_TWO 2'h3
// Address fields
`define ADDR_STATION_HI 5
`define ADDR_STATION_LO 6
`define ADDR_EQUIP_LSB 7
`define ADDR_EQUIP_MSB 10
`define ADDR_CONV_LSB 11
`define ADDR_CONV_MSB 15
`define ADDR_GUARD 0
// Director function bits
`define FN_CLEAR_ALL 0
`define FN_CLEAR_IRQ 1
`define FN_REQ_DATA 2
`define FN_REQ_EOP 3
`define FN_REQ_ALARM 4
`define FN_FEED 7
// Level-one status bits
`define ST_READY 0
`define ST_BUSY 1
`define ST_IRQ 2
`define ST_DATA 3
`define ST_EOP 4
`define ST_ALARM 5
`define ST_LOST 6
`define ST_GUARD 7
`define ST_NOT_READY 9
// Fixed words
`define LEVEL_TWO_WORD 16'h0000
`define COLUMN_WIDTH 12
`define FIFO_DEPTH 32
`endif

// >>> hdl/card_reader_pkg.sv
// Types shared by the card reader host port
`default_nettype none
package card_reader_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } chan_req_t;
    typedef struct packed {
        logic reply;
        logic reject;
        logic [15:0] rdata;
    } chan_rsp_t;
    typedef struct packed {
        logic data;
        logic eop;
        logic alarm;
        logic common;
    } irq_lines_t;
    typedef enum logic [1:0] {
        CARD_IDLE,
        CARD_FEEDING,
        CARD_LOCKED
    } card_state_t;
endpackage
`default_nettype wire

// >>> hdl/column_fifo.sv
// Column word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module column_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (clear) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/card_reader_port.sv
// Host channel control, status and interrupt logic of the card reader port
`timescale 1ns/1ps
`default_nettype none
`include "card_reader_defs.svh"
// Notes on behaviour
// - Clears reset alarm interrupt response
// - Unused function bits ignored, bit 8 included
// - Feed bit starts a reader feed cycle
// - Early feed truncates card, no end interrupt
// - Feed wins over clear controller
// - Level-one status read always replies
// - Status bit 0 shows reader ready
// - Busy from feed until end of operation
// - Status bit 2 shows any interrupt
// - Data interrupt is request and data
// - End interrupt is request and end status
// - Alarm interrupt is request and alarm
// - Common interrupt ORs the three lines
// - Data bit until host reads word
// - End status set when card finished
// - Alarm on ready loss or lost data
// - Lost data blocks transfers until clear or feed
// - Guard absent: only guarded instructions accepted
// - Status reads never rejected for guard
// - Level-one bits 8, 10-15 read zero
// - Not-ready bit inverts ready bit
// - Level-two read replies with zero word
// - Respond only on matching equipment, zero converter
// - Data read replies only when data valid
// - Not ready rejects all writes but clears, requests
module card_reader_port (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic master_clear,
    input wire card_reader_pkg::chan_req_t chan_req,
    output card_reader_pkg::chan_rsp_t chan_rsp,
    output card_reader_pkg::irq_lines_t irq,
    input wire logic [3:0] equip_jumpers,
    input wire logic write_guard_jumper,
    input wire logic reader_ready,
    input wire logic col_strobe,
    input wire logic [`COLUMN_WIDTH-1:0] col_data,
    input wire logic card_done,
    output logic feed
);
    import card_reader_pkg::*;

    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // ==========================================
    // Pin synchronisers
    logic [1:0] rdy_s;
    logic [1:0] stb_s;
    logic [1:0] done_s;
    logic [1:0] grd_s;
    logic [3:0] eq_s1;
    logic [3:0] eq_s2;
    logic rdy_d;
    logic stb_d;
    logic done_d;
    logic [`COLUMN_WIDTH-1:0] col_s1;
    logic [`COLUMN_WIDTH-1:0] col_s2;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdy_s <= '0;
            stb_s <= '0;
            done_s <= '0;
            grd_s <= '0;
            eq_s1 <= '0;
            eq_s2 <= '0;
            col_s1 <= '0;
            col_s2 <= '0;
        end else begin
            rdy_s <= {rdy_s[0], reader_ready};
            stb_s <= {stb_s[0], col_strobe};
            done_s <= {done_s[0], card_done};
            grd_s <= {grd_s[0], write_guard_jumper};
            eq_s1 <= equip_jumpers;
            eq_s2 <= eq_s1;
            col_s1 <= col_data;
            col_s2 <= col_s1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdy_d <= 1'b0;
            stb_d <= 1'b0;
            done_d <= 1'b0;
        end else begin
            rdy_d <= rdy_s[1];
            stb_d <= stb_s[1];
            done_d <= done_s[1];
        end
    end

    logic ready;
    logic strobe_pulse;
    logic done_pulse;
    logic ready_fall;
    logic guarded;
    assign ready = rdy_s[1];
    assign strobe_pulse = stb_s[1] && !stb_d;
    assign done_pulse = done_s[1] && !done_d;
    assign ready_fall = rdy_d && !rdy_s[1];
    // Jumper out means protected state
    assign guarded = !grd_s[1];

    // ==========================================
    // Access decode
    function automatic logic station_ok(input logic [15:0] a);
        station_ok = a[`ADDR_STATION_HI] && !a[`ADDR_STATION_LO];
    endfunction

    logic selected;
    logic access;
    logic guard_ok;
    logic [1:0] cmd;
    logic [15:0] fn;
    logic do_fn;
    logic do_read_data;
    logic fn_only_clr_req;
    logic fifo_valid;
    logic lost_r;
    logic [`COLUMN_WIDTH-1:0] fifo_data;

    assign selected = (chan_req.addr[`ADDR_EQUIP_MSB:`ADDR_EQUIP_LSB] == eq_s2)
        && (chan_req.addr[`ADDR_CONV_MSB:`ADDR_CONV_LSB] == '0);
    assign access = (chan_req.rd || chan_req.wr) && selected;
    assign guard_ok = !guarded || chan_req.addr[`ADDR_GUARD];
    assign cmd = chan_req.addr[1:0];
    assign fn = chan_req.wdata;
    // Only clears and interrupt requests (bits 5,6,8+ ignored)
    assign fn_only_clr_req = !fn[`FN_FEED];
    assign do_fn = access && chan_req.wr && cmd == `CMD_LEVEL_ONE
        && guard_ok && station_ok(chan_req.addr)
        && (ready || fn_only_clr_req);
    assign do_read_data = access && chan_req.rd && cmd == `CMD_READ_DATA
        && guard_ok && station_ok(chan_req.addr) && fifo_valid
        && !lost_r;

    logic clr_all;
    logic clr_irq;
    logic feed_cmd;
    assign feed_cmd = do_fn && fn[`FN_FEED];
    // Feed takes precedence: the clear-all is suppressed
    assign clr_all = master_clear
        || (do_fn && fn[`FN_CLEAR_ALL] && !fn[`FN_FEED]);
    assign clr_irq = clr_all || (do_fn && fn[`FN_CLEAR_IRQ]);

    // ==========================================
    // Card transport state
    card_state_t card_r;
    logic busy_r;
    logic eop_r;
    logic alarm_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            card_r <= CARD_IDLE;
        end else if (feed_cmd) begin
            // Early feed locks out rest of old card
            card_r <= (card_r == CARD_IDLE) ? CARD_FEEDING : CARD_LOCKED;
        end else if (clr_all) begin
            card_r <= CARD_IDLE;
        end else begin
            case (card_r)
                CARD_IDLE: card_r <= CARD_IDLE;
                CARD_FEEDING: if (done_pulse) card_r <= CARD_IDLE;
                CARD_LOCKED: if (done_pulse) card_r <= CARD_FEEDING;
                default: card_r <= CARD_IDLE;
            endcase
        end
    end

    assign busy_r = (card_r != CARD_IDLE);
    assign feed = busy_r;

    // End of operation only for the last card read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            eop_r <= 1'b0;
        end else if (card_r == CARD_FEEDING && done_pulse && !feed_cmd) begin
            eop_r <= 1'b1;
        end else if (clr_all || feed_cmd) begin
            eop_r <= 1'b0;
        end
    end

    // ==========================================
    // Column data path
    logic push;
    logic fifo_ready;
    logic fifo_clear;
    assign push = strobe_pulse && card_r == CARD_FEEDING && !lost_r;
    assign fifo_clear = clr_all || feed_cmd;

    // Lost data: column arrives while buffer still full
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lost_r <= 1'b0;
        end else if (push && !fifo_ready) begin
            lost_r <= 1'b1;
        end else if (clr_all || feed_cmd) begin
            lost_r <= 1'b0;
        end
    end

    column_fifo #(
        .WIDTH(`COLUMN_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(fifo_clear),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(col_s2),
        .out_valid(fifo_valid),
        .out_ready(do_read_data),
        .out_data(fifo_data)
    );

    // Alarm on ready loss or lost data; set wins over clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            alarm_r <= 1'b0;
        end else if (ready_fall || (push && !fifo_ready)) begin
            alarm_r <= 1'b1;
        end else if (clr_all) begin
            alarm_r <= 1'b0;
        end
    end

    // ==========================================
    // Interrupt requests
    logic req_data_r;
    logic req_eop_r;
    logic req_alarm_r;

    // Request beats clear in one write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            req_data_r <= 1'b0;
            req_eop_r <= 1'b0;
            req_alarm_r <= 1'b0;
        end else begin
            if (do_fn && fn[`FN_REQ_DATA]) begin
                req_data_r <= 1'b1;
            end else if (clr_irq) begin
                req_data_r <= 1'b0;
            end
            if (do_fn && fn[`FN_REQ_EOP]) begin
                req_eop_r <= 1'b1;
            end else if (clr_irq) begin
                req_eop_r <= 1'b0;
            end
            if (do_fn && fn[`FN_REQ_ALARM] && !master_clear) begin
                req_alarm_r <= 1'b1;
            end else if (clr_irq) begin
                req_alarm_r <= 1'b0;
            end
        end
    end

    logic data_st;
    assign data_st = fifo_valid && !lost_r;
    assign irq.data = req_data_r && data_st;
    assign irq.eop = req_eop_r && eop_r;
    assign irq.alarm = req_alarm_r && alarm_r;
    assign irq.common = irq.data || irq.eop || irq.alarm;

    // ==========================================
    // Status words and answers
    logic [15:0] status_one;
    always_comb begin
        status_one = 16'h0000;
        status_one[`ST_READY] = ready;
        status_one[`ST_BUSY] = busy_r;
        status_one[`ST_IRQ] = irq.common;
        status_one[`ST_DATA] = data_st;
        status_one[`ST_EOP] = eop_r;
        status_one[`ST_ALARM] = alarm_r;
        status_one[`ST_LOST] = lost_r;
        status_one[`ST_GUARD] = guarded;
        status_one[`ST_NOT_READY] = !ready;
    end

    logic ok;
    logic [15:0] word;
    always_comb begin
        ok = 1'b0;
        word = 16'h0000;
        if (chan_req.rd && cmd == `CMD_LEVEL_ONE) begin
            ok = 1'b1;
            word = status_one;
        end else if (chan_req.rd && cmd == `CMD_LEVEL_TWO) begin
            ok = 1'b1;
            word = `LEVEL_TWO_WORD;
        end else if (chan_req.rd && cmd == `CMD_READ_DATA) begin
            ok = do_read_data;
            word = {{(16-`COLUMN_WIDTH){1'b0}}, fifo_data};
        end else if (chan_req.wr) begin
            ok = do_fn;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_rsp <= '0;
        end else begin
            chan_rsp.reply <= access && ok;
            chan_rsp.reject <= access && !ok;
            chan_rsp.rdata <= (access && ok && chan_req.rd) ? word : 16'h0000;
        end
    end

    // ==========================================
    // Checks
    sequence s_lvl1_read;
        access && chan_req.rd && cmd == `CMD_LEVEL_ONE;
    endsequence
    sequence s_lvl2_read;
        access && chan_req.rd && cmd == `CMD_LEVEL_TWO;
    endsequence
    sequence s_feed_write;
        do_fn && fn[`FN_FEED];
    endsequence

    property p_feed_busy;
        s_feed_write |=> feed;
    endproperty
    a_feed_busy: assert property (p_feed_busy)
        else $error("feed line not raised");
    property p_busy_hold;
        busy_r && !done_pulse && !clr_all |=> status_one[`ST_BUSY];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped before end");
    property p_common;
        irq.common == ((req_data_r && data_st) || (req_eop_r && eop_r)
            || (req_alarm_r && alarm_r));
    endproperty
    a_common: assert property (p_common)
        else $error("common irq wrong");
    property p_lvl1;
        s_lvl1_read |=> chan_rsp.reply && !chan_rsp.reject;
    endproperty
    a_lvl1: assert property (p_lvl1)
        else $error("level one rejected");
    property p_lvl2;
        s_lvl2_read |=> chan_rsp.reply && chan_rsp.rdata == 16'h0000;
    endproperty
    a_lvl2: assert property (p_lvl2)
        else $error("level two wrong");
    property p_notready;
        s_lvl1_read |=> chan_rsp.rdata[`ST_NOT_READY]
            != chan_rsp.rdata[`ST_READY];
    endproperty
    a_notready: assert property (p_notready)
        else $error("not ready mismatch");
    property p_clr_alarm;
        clr_irq && !(do_fn && fn[`FN_REQ_ALARM]) |=> !irq.alarm;
    endproperty
    a_clr_alarm: assert property (p_clr_alarm)
        else $error("alarm irq not cleared");
    property p_feed_wins;
        do_fn && fn[`FN_FEED] && fn[`FN_CLEAR_ALL] && !master_clear
            |=> busy_r;
    endproperty
    a_feed_wins: assert property (p_feed_wins)
        else $error("clear beat feed");
    property p_lost_block;
        lost_r && access && chan_req.rd && cmd == `CMD_READ_DATA
            |=> chan_rsp.reject;
    endproperty
    a_lost_block: assert property (p_lost_block)
        else $error("transfer after lost data");
    property p_unsel;
        (chan_req.rd || chan_req.wr) && !selected
            |=> !chan_rsp.reply && !chan_rsp.reject;
    endproperty
    a_unsel: assert property (p_unsel)
        else $error("answered foreign address");
endmodule
`default_nettype wire

// >>> tb/card_reader_model.sv
// Behavioural card reader transport driven by the feed line
`timescale 1ns/1ps
`default_nettype none
module card_reader_model #(
    parameter int NCOL = 24
) (
    input wire logic clk_sys,
    input wire logic feed,
    output logic col_strobe,
    output logic [11:0] col_data,
    output logic card_done
);
    int col = 0;
    int p = 0;
    int g = 0;
    logic run = 1'b0;
    initial begin
        col_strobe = 1'b0;
        card_done = 1'b0;
        col_data = 12'h000;
    end
    // ==========================================
    // Columns of eight cycles, strobe in the middle
    always @(posedge clk_sys) begin
        #1;
        if (run) begin
            col_data = (p < 7) ? 12'ha00 + 12'(col) : ~col_data;
            col_strobe = (p >= 2 && p <= 4);
            p = p + 1;
            if (p == 8) begin
                p = 0;
                col = col + 1;
                if (col == NCOL) begin
                    run = 1'b0;
                    g = 12;
                end
            end
        end else begin
            // Data lines toggle while nothing is presented
            col_data = ~col_data;
            card_done = (g > 9);
            if (g > 0) begin
                g = g - 1;
            end else if (feed) begin
                run = 1'b1;
                col = 0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_card_reader_host_port_status.sv
// Self-checking bench for the card reader host port
`timescale 1ns/1ps
`default_nettype none
module test_card_reader_host_port_status;
    import card_reader_pkg::*;
    localparam logic [3:0] EQ = 4'h9;
    // Longer than the column buffer so one card can overrun it
    localparam int NCOL = 40;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic master_clear = 1'b0;
    chan_req_t chan_req = '0;
    chan_rsp_t chan_rsp;
    chan_rsp_t rsp;
    irq_lines_t irq;
    logic guard_in = 1'b1;
    logic reader_ready = 1'b1;
    logic col_strobe;
    logic card_done;
    logic feed;
    logic [11:0] col_data;
    int failures = 0;
    int compares = 0;
    int i;

    always #5 clk_sys = ~clk_sys;

    card_reader_port i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .master_clear(master_clear),
        .chan_req(chan_req), .chan_rsp(chan_rsp), .irq(irq),
        .equip_jumpers(EQ), .write_guard_jumper(guard_in),
        .reader_ready(reader_ready), .col_strobe(col_strobe),
        .col_data(col_data), .card_done(card_done), .feed(feed)
    );

    card_reader_model #(.NCOL(NCOL)) i_reader (
        .clk_sys(clk_sys), .feed(feed), .col_strobe(col_strobe),
        .col_data(col_data), .card_done(card_done)
    );

    // ==========================================
    // Access and compare tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] qa(input logic [1:0] cmd);
        return {5'h00, EQ, 2'h1, 3'h0, cmd};
    endfunction

    task automatic acc(input logic wr, input logic [15:0] a,
        input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        chan_req = '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge clk_sys);
        #1;
        chan_req = '0;
        rsp = chan_rsp;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [1:0] rr,
        input logic [15:0] dat);
        acc(1'b0, a, 16'h0000);
        chk({14'h0, rsp.reply, rsp.reject}, {14'h0, rr});
        chk(rsp.rdata, dat);
    endtask

    task automatic wr_chk(input logic [15:0] d, input logic [1:0] rr);
        acc(1'b1, qa(2'h1), d);
        chk({14'h0, rsp.reply, rsp.reject}, {14'h0, rr});
    endtask

    task automatic wait_bit(input int b);
        for (int n = 0; n < 1000; n++) begin
            acc(1'b0, qa(2'h1), 16'h0000);
            if (rsp.rdata[b] === 1'b1) return;
        end
        chk({15'h0, rsp.rdata[b]}, 16'h0001);
    endtask

    task automatic done(input string name);
        $display("Test %s finished", name);
    endtask

    task automatic stop_test();
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        stop_test();
    end

    // ==========================================
    // Test sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk(qa(2'h1), 2'b10, 16'h0001);
        rd_chk(qa(2'h3), 2'b10, 16'h0000);
        rd_chk(qa(2'h2), 2'b01, 16'h0000);
        rd_chk(qa(2'h1) ^ 16'h0080, 2'b00, 16'h0000);
        rd_chk(qa(2'h1) | 16'h0800, 2'b00, 16'h0000);
        rd_chk(qa(2'h0), 2'b01, 16'h0000);
        wr_chk(16'hfe60, 2'b10);
        rd_chk(qa(2'h1), 2'b10, 16'h0001);
        done("idle");
        wr_chk(16'h018c, 2'b10);
        chk({15'h0, feed}, 16'h0001);
        wait_bit(3);
        chk({12'h0, rsp.rdata[3:0]}, 16'h000f);
        chk({12'h0, irq}, 16'h0009);
        rd_chk(qa(2'h0) ^ 16'h0020, 2'b01, 16'h0000);
        for (i = 0; i < NCOL; i++) begin
            wait_bit(3);
            rd_chk(qa(2'h0), 2'b10, {4'h0, 12'ha00 + 12'(i)});
        end
        wait_bit(4);
        rd_chk(qa(2'h1), 2'b10, 16'h0015);
        chk({12'h0, irq}, 16'h0005);
        chk({15'h0, feed}, 16'h0000);
        wr_chk(16'h0002, 2'b10);
        chk({12'h0, irq}, 16'h0000);
        rd_chk(qa(2'h1), 2'b10, 16'h0011);
        done("feed");
        wr_chk(16'h0088, 2'b10);
        wait_bit(3);
        rd_chk(qa(2'h0), 2'b10, 16'h0a00);
        wr_chk(16'h0080, 2'b10);
        @(posedge card_done);
        repeat (8) @(posedge clk_sys);
        acc(1'b0, qa(2'h1), 16'h0000);
        chk({14'h0, rsp.rdata[4], rsp.rdata[1]}, 16'h0001);
        chk({15'h0, irq.eop}, 16'h0000);
        for (i = 0; i < 600; i++) begin
            acc(1'b0, qa(2'h0), 16'h0000);
            acc(1'b0, qa(2'h1), 16'h0000);
            if (rsp.rdata[4] === 1'b1) break;
        end
        chk({12'h0, rsp.rdata[6], rsp.rdata[4], rsp.rdata[2],
            rsp.rdata[1]}, 16'h0006);
        chk({15'h0, irq.eop}, 16'h0001);
        wr_chk(16'h0001, 2'b10);
        rd_chk(qa(2'h1), 2'b10, 16'h0001);
        done("early_feed");
        wr_chk(16'h0090, 2'b10);
        wr_chk(16'h0080, 2'b10);
        wait_bit(4);
        wait_bit(5);
        wait_bit(6);
        rd_chk(qa(2'h1), 2'b10, 16'h0075);
        chk({12'h0, irq}, 16'h0003);
        rd_chk(qa(2'h0), 2'b01, 16'h0000);
        wr_chk(16'h0001, 2'b10);
        rd_chk(qa(2'h1), 2'b10, 16'h0001);
        chk({12'h0, irq}, 16'h0000);
        done("lost_data");
        wr_chk(16'h0010, 2'b10);
        @(posedge clk_sys);
        #1;
        reader_ready = 1'b0;
        repeat (6) @(posedge clk_sys);
        rd_chk(qa(2'h1), 2'b10, 16'h0224);
        chk({12'h0, irq}, 16'h0003);
        wr_chk(16'h0080, 2'b01);
        wr_chk(16'h0002, 2'b10);
        chk({12'h0, irq}, 16'h0000);
        rd_chk(qa(2'h1), 2'b10, 16'h0220);
        reader_ready = 1'b1;
        @(posedge clk_sys);
        #1;
        master_clear = 1'b1;
        @(posedge clk_sys);
        #1;
        master_clear = 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_chk(qa(2'h1), 2'b10, 16'h0001);
        done("ready_loss");
        guard_in = 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_chk(qa(2'h1), 2'b10, 16'h0081);
        rd_chk(qa(2'h3), 2'b10, 16'h0000);
        wr_chk(16'h0080, 2'b10);
        wait_bit(3);
        rd_chk(qa(2'h0), 2'b01, 16'h0000);
        guard_in = 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk(qa(2'h0), 2'b10, 16'h0a00);
        wr_chk(16'h0001, 2'b10);
        done("guard");
        wr_chk(16'h0081, 2'b10);
        chk({15'h0, feed}, 16'h0001);
        repeat (2) @(posedge clk_sys);
        done("feed_over_clear");
        stop_test();
    end
endmodule
`default_nettype wire
